// File: shared/t16oc_map.vh
// Address map, fields, modes and constants of the timer compare block.
// Assumes an APB slave decoding byte address bits 7:0.
`ifndef T16OC_MAP_VH
`define T16OC_MAP_VH
// --------------------------------
// Register offsets
// --------------------------------
`define T16_A_CTRL    8'h00
`define T16_A_FORCE   8'h04
`define T16_A_CNT_LO  8'h08
`define T16_A_CNT_HI  8'h0c
`define T16_A_CMPA_LO 8'h10
`define T16_A_CMPA_HI 8'h14
`define T16_A_CMPB_LO 8'h18
`define T16_A_CMPB_HI 8'h1c
`define T16_A_CAP_LO  8'h20
`define T16_A_CAP_HI  8'h24
`define T16_A_FLAGS   8'h28
// --------------------------------
// Fields
// --------------------------------
`define T16_W_CTRL    11
`define T16_F_MODE    3:0
`define T16_F_ACT     4
`define T16_F_IE      8
`define T16_F_OVIE    10
`define T16_B_OVF     2
`define T16_RST_CTRL  11'h000
`define T16_RST_16    16'h0000
`define T16_RST_8     8'h00
// --------------------------------
// Modes and actions
// --------------------------------
`define T16_M_NORMAL  4'h0
`define T16_M_CTC_A   4'h4
`define T16_M_CTC_C   4'hc
`define T16_M_RSVD    4'hd
`define T16_ACT_NONE  2'h0
`define T16_ACT_TGL   2'h1
`define T16_ACT_CLR   2'h2
`define T16_ACT_SET   2'h3
`define T16_TOP_8     16'h00ff
`define T16_TOP_9     16'h01ff
`define T16_TOP_10    16'h03ff
`define T16_MAX       16'hffff
`define T16_ONE       16'h0001
`endif

// File: hdl/t16oc_top.v
// Compare section of a 16-bit timer with two channels, behind APB.
// Assumes the timer clock arrives as a synchronous enable pulse.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "t16oc_map.vh"
module t16oc_top (
  input  wire        I_CLK_SYS,
  input  wire        I_NRST,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [7:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output wire        O_PREADY,
  output wire        O_PSLVERR,
  input  wire        I_TCLK_EN,
  input  wire        I_INT_ACK_CMPA,
  input  wire        I_INT_ACK_CMPB,
  input  wire        I_INT_ACK_OVF,
  input  wire        I_PORT_VAL_A,
  input  wire        I_PORT_VAL_B,
  input  wire        I_OUTPUT_DIRECTION_BIT_A,
  input  wire        I_OUTPUT_DIRECTION_BIT_B,
  output wire        O_PIN_A,
  output wire        O_PIN_A_OE_N,
  output wire        O_PIN_B,
  output wire        O_PIN_B_OE_N,
  output wire        O_MATCH_A,
  output wire        O_MATCH_B,
  output wire        O_IRQ_CMPA,
  output wire        O_IRQ_CMPB,
  output wire        O_IRQ_OVF
);

  // --------------------------------
  // Mode decoding
  // --------------------------------
  function is_pwm;
    input [3:0] m;
    begin
      is_pwm = !(m == `T16_M_NORMAL || m == `T16_M_CTC_A ||
                 m == `T16_M_CTC_C  || m == `T16_M_RSVD);
    end
  endfunction

  function is_dual;
    input [3:0] m;
    begin
      is_dual = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
    end
  endfunction

  function [15:0] top_of;
    input [3:0]  m;
    input [15:0] cmpa;
    input [15:0] cap;
    begin
      case (m)
        4'h1, 4'h5: top_of = `T16_TOP_8;
        4'h2, 4'h6: top_of = `T16_TOP_9;
        4'h3, 4'h7: top_of = `T16_TOP_10;
        4'h4, 4'h9, 4'hb, 4'hf: top_of = cmpa;
        4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
        default: top_of = `T16_MAX;
      endcase
    end
  endfunction

  // --------------------------------
  // State
  // --------------------------------
  reg  [10:0] ctrl_r;
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;
  reg  [15:0] cap_r;
  reg  [7:0]  temp_r;
  reg  [7:0]  snap_r;
  reg         dir_r;
  reg         dir_nxt;
  reg         block_r;
  reg         ovf_r;
  reg         tov_evt;
  reg         upd_evt;
  reg         top_evt;
  reg         map_ok;
  reg  [31:0] rd_nxt;

  wire [3:0]  mode    = ctrl_r[`T16_F_MODE];
  wire        pwm     = is_pwm(mode);
  wire        dual    = is_dual(mode);
  wire        bot_upd = (mode == 4'h8) || (mode == 4'h9);
  wire        tick    = I_TCLK_EN;
  wire [15:0] cmpa;
  wire [15:0] cmpb;
  wire [15:0] bufa;
  wire [15:0] bufb;
  wire [1:0]  flag;
  wire [15:0] top     = top_of(mode, cmpa, cap_r);
  wire        has_top = pwm || mode == `T16_M_CTC_A || mode == `T16_M_CTC_C;
  wire        top_hit = has_top && (cnt_r == top) && !block_r;

  // --------------------------------
  // APB access
  // --------------------------------
  wire        setup   = I_PSEL && !I_PENABLE;
  wire        acc     = I_PSEL && I_PENABLE;
  wire        wr      = acc && I_PWRITE && map_ok;
  wire        rd      = acc && !I_PWRITE && map_ok;
  wire [7:0]  wbyte   = I_PWDATA[7:0];
  wire        wr_cnt  = wr && (I_PADDR == `T16_A_CNT_LO);
  wire        wr_frc  = wr && (I_PADDR == `T16_A_FORCE) && !pwm;
  wire        wr_flg  = wr && (I_PADDR == `T16_A_FLAGS);
  wire [1:0]  wr_lo   = {wr && (I_PADDR == `T16_A_CMPB_LO),
                         wr && (I_PADDR == `T16_A_CMPA_LO)};

  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = acc && !map_ok;

  always @* begin
    map_ok = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (I_PADDR)
      `T16_A_CTRL:    rd_nxt[10:0] = ctrl_r;
      `T16_A_FORCE:   rd_nxt = 32'h0000_0000;
      `T16_A_CNT_LO:  rd_nxt[7:0] = cnt_r[7:0];
      `T16_A_CNT_HI:  rd_nxt[7:0] = temp_r;
      `T16_A_CMPA_LO: rd_nxt[7:0] = pwm ? bufa[7:0] : cmpa[7:0];
      `T16_A_CMPA_HI: rd_nxt[7:0] = pwm ? bufa[15:8] : cmpa[15:8];
      `T16_A_CMPB_LO: rd_nxt[7:0] = pwm ? bufb[7:0] : cmpb[7:0];
      `T16_A_CMPB_HI: rd_nxt[7:0] = pwm ? bufb[15:8] : cmpb[15:8];
      `T16_A_CAP_LO:  rd_nxt[7:0] = cap_r[7:0];
      `T16_A_CAP_HI:  rd_nxt[7:0] = cap_r[15:8];
      `T16_A_FLAGS:   rd_nxt[2:0] = {ovf_r, flag};
      default:        map_ok = 1'b0;
    endcase
  end

  // Read data is staged in the setup phase, so the access phase is zero wait
  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PRDATA <= 32'h0000_0000;
      snap_r   <= `T16_RST_8;
    end else if (setup) begin
      O_PRDATA <= rd_nxt;
      snap_r   <= cnt_r[15:8];
    end
  end

  // Shared holding byte for every sixteen-bit write and the counter read
  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      temp_r <= `T16_RST_8;
    end else if (wr && (I_PADDR == `T16_A_CNT_HI || I_PADDR == `T16_A_CMPA_HI ||
                        I_PADDR == `T16_A_CMPB_HI || I_PADDR == `T16_A_CAP_HI)) begin
      temp_r <= wbyte;
    end else if (rd && I_PADDR == `T16_A_CNT_LO) begin
      temp_r <= snap_r;
    end
  end

  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_r <= `T16_RST_CTRL;
      cap_r  <= `T16_RST_16;
    end else begin
      if (wr && I_PADDR == `T16_A_CTRL)
        ctrl_r <= I_PWDATA[10:0];
      if (wr && I_PADDR == `T16_A_CAP_LO)
        cap_r <= {temp_r, wbyte};
    end
  end

  // --------------------------------
  // Counter
  // --------------------------------
  always @* begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    tov_evt = 1'b0;
    upd_evt = 1'b0;
    top_evt = 1'b0;
    if (wr_cnt) begin
      cnt_nxt = {temp_r, wbyte};
    end else if (tick) begin
      if (dual) begin
        if (!dir_r && top_hit) begin
          cnt_nxt = cnt_r - `T16_ONE;
          dir_nxt = 1'b1;
          upd_evt = !bot_upd;
        end else if (dir_r && cnt_r == `T16_RST_16) begin
          cnt_nxt = cnt_r + `T16_ONE;
          dir_nxt = 1'b0;
          tov_evt = 1'b1;
          upd_evt = bot_upd;
        end else if (dir_r) begin
          cnt_nxt = cnt_r - `T16_ONE;
        end else begin
          cnt_nxt = cnt_r + `T16_ONE;
        end
      end else if (top_hit) begin
        cnt_nxt = `T16_RST_16;
        top_evt = 1'b1;
        tov_evt = pwm;
        upd_evt = pwm;
      end else begin
        cnt_nxt = cnt_r + `T16_ONE;
        tov_evt = (cnt_r == `T16_MAX);
      end
    end
  end

  // Blocking holds across a stopped timer until the next timer clock
  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cnt_r   <= `T16_RST_16;
      dir_r   <= 1'b0;
      block_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dir_r <= dual ? dir_nxt : 1'b0;
      if (wr_cnt)
        block_r <= 1'b1;
      else if (tick)
        block_r <= 1'b0;
    end
  end

  // Set wins over a same-cycle clear
  always @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST)
      ovf_r <= 1'b0;
    else if (tov_evt)
      ovf_r <= 1'b1;
    else if (I_INT_ACK_OVF || (wr_flg && I_PWDATA[`T16_B_OVF]))
      ovf_r <= 1'b0;
  end

  assign O_IRQ_OVF = ovf_r && ctrl_r[`T16_F_OVIE];

  // --------------------------------
  // Compare channels
  // --------------------------------
  wire [1:0] ack      = {I_INT_ACK_CMPB, I_INT_ACK_CMPA};
  wire [1:0] port_val = {I_PORT_VAL_B, I_PORT_VAL_A};
  wire [1:0] ddr      = {I_OUTPUT_DIRECTION_BIT_B, I_OUTPUT_DIRECTION_BIT_A};
  wire [1:0] match;
  wire [1:0] pin;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      reg  [15:0] cmp_r;
      reg  [15:0] buf_r;
      reg         flag_r;
      reg         st_r;
      reg         st_nxt;
      wire [1:0]  act = ctrl_r[`T16_F_ACT + 2 * g +: 2];
      wire        hit = tick && match[g] && !block_r;
      wire        frc = wr_frc && I_PWDATA[g];

      assign match[g] = (cnt_r == cmp_r);

      // Hardware never rewrites these except the buffer transfer
      always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
          cmp_r <= `T16_RST_16;
          buf_r <= `T16_RST_16;
        end else begin
          if (wr_lo[g] && pwm)
            buf_r <= {temp_r, wbyte};
          if (wr_lo[g] && !pwm)
            cmp_r <= {temp_r, wbyte};
          else if (upd_evt)
            cmp_r <= buf_r;
        end
      end

      always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST)
          flag_r <= 1'b0;
        else if (hit)
          flag_r <= 1'b1;
        else if (ack[g] || (wr_flg && I_PWDATA[g]))
          flag_r <= 1'b0;
      end

      always @* begin
        st_nxt = st_r;
        if (act != `T16_ACT_NONE) begin
          if (!pwm) begin
            if (hit || frc) begin
              case (act)
                `T16_ACT_TGL: st_nxt = !st_r;
                `T16_ACT_CLR: st_nxt = 1'b0;
                `T16_ACT_SET: st_nxt = 1'b1;
                default:      st_nxt = st_r;
              endcase
            end
          end else if (dual) begin
            if (hit && act[1])
              st_nxt = dir_r ? !act[0] : act[0];
          end else begin
            if (hit && act[1])
              st_nxt = !act[0];
            if (top_evt && act[1])
              st_nxt = act[0];
          end
        end
      end

      always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST)
          st_r <= 1'b0;
        else
          st_r <= st_nxt;
      end

      assign pin[g]   = (act != `T16_ACT_NONE) ? st_r : port_val[g];
      assign flag[g]  = flag_r;
    end
  endgenerate

  assign cmpa = ch[0].cmp_r;
  assign cmpb = ch[1].cmp_r;
  assign bufa = ch[0].buf_r;
  assign bufb = ch[1].buf_r;

  // --------------------------------
  // Outputs
  // --------------------------------
  assign O_MATCH_A    = match[0];
  assign O_MATCH_B    = match[1];
  assign O_IRQ_CMPA   = flag[0] && ctrl_r[`T16_F_IE];
  assign O_IRQ_CMPB   = flag[1] && ctrl_r[`T16_F_IE + 1];
  assign O_PIN_A      = pin[0];
  assign O_PIN_B      = pin[1];
  assign O_PIN_A_OE_N = !ddr[0];
  assign O_PIN_B_OE_N = !ddr[1];

endmodule // t16oc_top

// File: tb/t16oc_asserts.sv
// Port checker of the timer compare block.
// Assumes one clock and an async active-low reset.
`timescale 1ns/1ps
module t16oc_asserts (
  input wire I_CLK_SYS,
  input wire I_NRST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire I_TCLK_EN,
  input wire I_INT_ACK_CMPA,
  input wire I_PORT_VAL_A,
  input wire I_OUTPUT_DIRECTION_BIT_A,
  input wire I_OUTPUT_DIRECTION_BIT_B,
  input wire O_PIN_A,
  input wire O_PIN_A_OE_N,
  input wire O_PIN_B_OE_N,
  input wire O_MATCH_A,
  input wire O_IRQ_CMPA,
  input wire O_IRQ_OVF
);
  wire wr = I_PSEL & I_PENABLE & I_PWRITE;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  // ----------------
  // Assertions
  // ----------------
  dir_pin_a_a: assert property (O_PIN_A_OE_N == !I_OUTPUT_DIRECTION_BIT_A)
    else $error("pin A direction wrong");
  dir_pin_b_a: assert property (O_PIN_B_OE_N == !I_OUTPUT_DIRECTION_BIT_B)
    else $error("pin B direction wrong");
  // Counter and compare move only on a tick or a bus write
  match_step_a: assert property ($changed(O_MATCH_A) |-> $past(I_TCLK_EN) || $past(wr))
    else $error("match A moved without cause");
  flag_tick_a: assert property ($rose(O_IRQ_CMPA) |-> $past(I_TCLK_EN) ||
    $past(I_TCLK_EN, 2) || $past(wr) || $past(wr, 2))
    else $error("compare A flag set off a tick");
  irq_hold_a: assert property ($fell(O_IRQ_CMPA) |-> $past(I_INT_ACK_CMPA) ||
    $past(I_INT_ACK_CMPA, 2) || $past(wr) || $past(wr, 2))
    else $error("compare A request dropped");
  ack_clear_a: assert property (I_INT_ACK_CMPA && !I_TCLK_EN |-> ##[1:3] !O_IRQ_CMPA)
    else $error("ack did not clear A");
  ovf_tick_a: assert property ($rose(O_IRQ_OVF) |-> $past(I_TCLK_EN) ||
    $past(I_TCLK_EN, 2) || $past(wr) || $past(wr, 2))
    else $error("overflow set off a tick");
  pin_step_a: assert property ($changed(O_PIN_A) |-> $past(I_TCLK_EN) ||
    $past(wr) || $changed(I_PORT_VAL_A))
    else $error("pin A moved without cause");
  cover property ($rose(O_IRQ_CMPA));
  cover property ($fell(O_IRQ_CMPA));
  cover property ($rose(O_IRQ_OVF));
endmodule // t16oc_asserts

bind t16oc_top t16oc_asserts u_chk (.I_CLK_SYS, .I_NRST, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_TCLK_EN, .I_INT_ACK_CMPA, .I_PORT_VAL_A, .I_OUTPUT_DIRECTION_BIT_A,
  .I_OUTPUT_DIRECTION_BIT_B, .O_PIN_A, .O_PIN_A_OE_N, .O_PIN_B_OE_N, .O_MATCH_A,
  .O_IRQ_CMPA, .O_IRQ_OVF);

// File: tb/t16oc_cpu.sv
// CPU model: APB master reaching the compare block.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module t16oc_cpu (
  input  wire        clk,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr,
  output reg         psel = 1'h0,
  output reg         penable = 1'h0,
  output reg         pwrite = 1'h0,
  output reg  [7:0]  paddr = 8'h0,
  output reg  [31:0] pwdata = 32'h0
);
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Stale data would hide a slave that samples late
    pwdata <= ~d;
  endtask
  // High byte first, so the low write lands all sixteen bits at once
  task wr16(input logic [7:0] hi_a, input logic [15:0] v);
    logic [31:0] q;
    logic        e;
    xfer(1'h1, hi_a, {24'h0, v[15:8]}, q, e);
    xfer(1'h1, hi_a - 8'h04, {24'h0, v[7:0]}, q, e);
  endtask
endmodule // t16oc_cpu

// File: tb/timer16_output_compare_bench.sv
// Self-checking bench of the timer compare block.
// Assumes the CPU model drives APB and the bench paces timer ticks.
`timescale 1ns/1ps
`include "t16oc_map.vh"
module timer16_output_compare_bench;
  logic        clk = 0, nrst = 0, tclk = 0, ack_a = 0, ack_b = 0, ack_o = 0;
  logic        port_a = 0, port_b = 0, ddr_a = 0, ddr_b = 0, er;
  logic        psel, pen, pwr, pready, perr, pin_a, oen_a, pin_b, oen_b;
  logic        m_a, m_b, irq_a, irq_b, irq_o;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          miscompares = 0;
  int          samples_checked = 0;
  // Rows: action[4:3] port[2] direction[1] expected pin[0]
  logic [4:0]  rows [7] = '{5'h1b, 5'h08, 5'h0b, 5'h02, 5'h0e, 5'h1b, 5'h14};
  always #2.5 clk = ~clk;
  t16oc_cpu cpu (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(perr),
    .psel(psel), .penable(pen), .pwrite(pwr), .paddr(paddr), .pwdata(pwdata));
  t16oc_top uut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(perr), .I_TCLK_EN(tclk), .I_INT_ACK_CMPA(ack_a),
    .I_INT_ACK_CMPB(ack_b), .I_INT_ACK_OVF(ack_o), .I_PORT_VAL_A(port_a),
    .I_PORT_VAL_B(port_b), .I_OUTPUT_DIRECTION_BIT_A(ddr_a),
    .I_OUTPUT_DIRECTION_BIT_B(ddr_b), .O_PIN_A(pin_a), .O_PIN_A_OE_N(oen_a),
    .O_PIN_B(pin_b), .O_PIN_B_OE_N(oen_b), .O_MATCH_A(m_a), .O_MATCH_B(m_b),
    .O_IRQ_CMPA(irq_a), .O_IRQ_CMPB(irq_b), .O_IRQ_OVF(irq_o));
  // ----------------
  // Helpers
  // ----------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'h1, a, d, q, er);
    #1;
  endtask
  task rd(input logic [7:0] a);
    cpu.xfer(1'h0, a, 32'h0, q, er);
  endtask
  task tick;
    @(posedge clk) tclk <= 1'h1;
    @(posedge clk) tclk <= 1'h0;
    #1;
  endtask
  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run is a few hundred cycles
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    rd(`T16_A_CTRL);
    chk("ctrl", 32'h0, q);
    wr(`T16_A_CTRL, 32'h20);
    chk("pin a", 32'h0, 32'(pin_a));
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      port_a <= rows[i][2];
      ddr_a <= rows[i][1];
      wr(`T16_A_CTRL, {26'h0, rows[i][4:3], 4'h0});
      wr(`T16_A_FORCE, 32'h1);
      chk("pin a", 32'(rows[i][0]), 32'(pin_a));
      chk("oe_n a", 32'(!rows[i][1]), 32'(oen_a));
      rd(`T16_A_FLAGS);
      chk("flags", 32'h0, q);
    end
    $display("test force table done");
    cpu.wr16(`T16_A_CMPA_HI, 16'h0105);
    cpu.wr16(`T16_A_CNT_HI, 16'h0103);
    tick;
    tick;
    chk("match a", 32'h1, 32'(m_a));
    rd(`T16_A_FLAGS);
    chk("flags", 32'h0, q);
    tick;
    rd(`T16_A_FLAGS);
    chk("flags", 32'h1, q);
    wr(`T16_A_CTRL, 32'h100);
    repeat (2) @(posedge clk);
    #1;
    chk("irq a", 32'h1, 32'(irq_a));
    @(posedge clk) ack_a <= 1'h1;
    @(posedge clk) ack_a <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("irq a", 32'h0, 32'(irq_a));
    wr(`T16_A_CNT_HI, 32'h77);
    rd(`T16_A_CMPA_HI);
    chk("cmpa hi", 32'h1, q);
    $display("test match timing done");
    cpu.wr16(`T16_A_CMPB_HI, 16'h0010);
    cpu.wr16(`T16_A_CNT_HI, 16'h0010);
    #1;
    chk("match b", 32'h1, 32'(m_b));
    tick;
    rd(`T16_A_FLAGS);
    chk("flags", 32'h0, q);
    wr(`T16_A_CTRL, 32'h400);
    cpu.wr16(`T16_A_CNT_HI, 16'hffff);
    tick;
    rd(`T16_A_FLAGS);
    chk("flags", 32'h4, q);
    chk("irq ovf", 32'h1, 32'(irq_o));
    rd(`T16_A_CNT_LO);
    chk("count lo", 32'h0, q);
    rd(`T16_A_CNT_HI);
    chk("count hi", 32'h0, q);
    wr(`T16_A_FLAGS, 32'h4);
    rd(`T16_A_FLAGS);
    chk("flags", 32'h0, q);
    chk("irq ovf", 32'h0, 32'(irq_o));
    rd(8'h30);
    chk("slverr", 32'h1, 32'(er));
    chk("rdata", 32'h0, q);
    $display("test flags and wrap done");
    wr(`T16_A_CTRL, 32'h2c0);
    wr(`T16_A_FORCE, 32'h2);
    chk("pin b", 32'h1, 32'(pin_b));
    chk("oe_n b", 32'h1, 32'(oen_b));
    chk("irq b", 32'h0, 32'(irq_b));
    cpu.wr16(`T16_A_CNT_HI, 16'h000f);
    tick;
    tick;
    chk("irq b", 32'h1, 32'(irq_b));
    // Fast PWM with channel A as top, channel B set on match and cleared at top
    wr(`T16_A_CTRL, 32'h8f);
    cpu.wr16(`T16_A_CMPB_HI, 16'h0020);
    rd(`T16_A_CMPB_LO);
    chk("cmpb lo", 32'h20, q);
    cpu.wr16(`T16_A_CNT_HI, 16'h0010);
    #1;
    chk("match b", 32'h1, 32'(m_b));
    cpu.wr16(`T16_A_CNT_HI, 16'h0104);
    tick;
    tick;
    chk("pin b", 32'h0, 32'(pin_b));
    rd(`T16_A_CNT_LO);
    chk("count lo", 32'h0, q);
    cpu.wr16(`T16_A_CNT_HI, 16'h001f);
    tick;
    tick;
    chk("pin b", 32'h1, 32'(pin_b));
    $display("test channel b and pwm done");
    wr(`T16_A_CTRL, 32'h30);
    wr(`T16_A_FORCE, 32'h1);
    wr(`T16_A_CTRL, 32'h34);
    chk("pin a", 32'h1, 32'(pin_a));
    @(posedge clk) nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    wr(`T16_A_CTRL, 32'h20);
    chk("pin a", 32'h0, 32'(pin_a));
    $display("test mode and reset done");
    give_verdict;
  end
endmodule // timer16_output_compare_bench
